// ==== common/mpsl_pkg.sv ====
// Shared constants, types and helpers of the multipoint select/poll link engine
package mpsl_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned TMO_MS = 5000;
   localparam int unsigned TMO_CYC = TMO_MS * (CLK_HZ / 1000);
   localparam int unsigned TMO_W = 28;

   // ----------------------------------------------------------------
   // Baud rates, index 0..9, default index 5 is 9600
   // ----------------------------------------------------------------
   localparam int unsigned BAUD_RATE [10] = '{300, 600, 1200, 2400, 4800, 9600,
                                             19200, 38400, 56000, 57600};
   localparam int unsigned BAUD_NUM = 10;
   localparam logic [3:0] BAUD_SEL_RST = 4'h5;
   localparam int unsigned DIV_W = 18;
   localparam logic [3:0] UART_BITS = 4'h8;

   // ----------------------------------------------------------------
   // Control characters and address suffixes
   // ----------------------------------------------------------------
   localparam logic [7:0] C_NUL = 8'h00;
   localparam logic [7:0] C_STX = 8'h02;
   localparam logic [7:0] C_ETX = 8'h03;
   localparam logic [7:0] C_EOT = 8'h04;
   localparam logic [7:0] C_ENQ = 8'h05;
   localparam logic [7:0] C_ACK = 8'h06;
   localparam logic [7:0] C_LF = 8'h0A;
   localparam logic [7:0] C_CR = 8'h0D;
   localparam logic [7:0] C_NAK = 8'h15;
   localparam logic [7:0] C_SPACE = 8'h20;
   localparam logic [7:0] C_DIG0 = 8'h30;
   localparam logic [15:0] SELECT_SUFFIX = 16'h7372;
   localparam logic [15:0] POLL_SUFFIX = 16'h706F;
   localparam logic [7:0] BCC_MSB = 8'h80;
   localparam logic [6:0] ADDR_RST = 7'h00;

   // ----------------------------------------------------------------
   // Configuration carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic bcc_en;
      logic [3:0] baud_sel;
      logic [6:0] group_addr;
      logic [6:0] user_addr;
   } mpsl_cfg_t;

   // Bit period in clocks for a baud index; out-of-range picks the default
   function automatic logic [DIV_W-1:0] mpsl_baud_div(input logic [3:0] sel,
                                                      input int unsigned clk_hz);
      int unsigned idx;
      idx = (32'(sel) < BAUD_NUM) ? 32'(sel) : 32'(BAUD_SEL_RST);
      return DIV_W'(clk_hz / BAUD_RATE[idx]);
   endfunction

   // Two ASCII decimal digits of an address 0..99
   function automatic logic [15:0] mpsl_dec2(input logic [6:0] v);
      logic [7:0] hi;
      logic [7:0] lo;
      hi = C_DIG0 + 8'(v / 7'd10);
      lo = C_DIG0 + 8'(v % 7'd10);
      return {hi, lo};
   endfunction

endpackage

// ==== test/mpsl_host.sv ====
// Serial control-station model facing the link engine
module mpsl_host #(
   parameter int DIV = 868
)(
   // Clock
   input wire logic clk_sys,
   // Serial lines seen from the host
   input wire logic txd,
   output logic rxd,
   // Received byte strobe
   output logic [7:0] rx_byte,
   output logic rx_stb
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;

   // Line idles high; there are no handshake lines to drive
   initial begin
      rxd = 1'b1;
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end

   // One 8N1 frame, line changed only at falling edges
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge clk_sys);
         rxd = f[i];
         repeat (DIV - 1) @(negedge clk_sys);
      end
   endtask

   // Closing the exchange: the host sends EOT at once, without waiting on the device
   task automatic end_conn();
      send_byte(8'h04);
   endtask

   // Mid-bit sampling of device frames; strobe lands off the rising edge
   always begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge clk_sys);
         sh[i] = txd;
      end
      repeat (DIV) @(posedge clk_sys);
      @(negedge clk_sys);
      rx_byte = sh;
      rx_stb = 1'b1;
      @(negedge clk_sys);
      rx_stb = 1'b0;
   end
endmodule

// ==== test/mpsl_link_tb_top.sv ====
// Self-checking bench of the select/poll link engine
module mpsl_link_tb_top
   import mpsl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // Fastest rate on a scaled clock figure keeps frames short; timers shortened to match
   localparam int CLK_F = 5_760_000;
   localparam int DIV = CLK_F / 57600;
   localparam int TMO = 3000;
   localparam int LIMIT = 120000;
   logic clk_sys, resetn, dev_ready, rsp_pending, rsp_valid, rsp_last, rxd, txd;
   logic cmd_valid, cmd_done, cmd_abort, rsp_take, addressed, talking, h_stb;
   logic [7:0] rsp_byte, cmd_byte, h_byte, g_hi, g_lo, u_hi, u_lo, cb;
   logic [7:0] exp_tx[$], exp_cmd[$], exp_end[$], rsp_q[$];
   mpsl_cfg_t cfg;
   int mismatches, n_checks, cyc, t0;

   mpsl_link #(.TMO_CYCLES(TMO), .CLK_FREQ(CLK_F)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
      .cfg(cfg),
      .rxd(rxd), .txd(txd), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
      .cmd_done(cmd_done), .cmd_abort(cmd_abort), .dev_ready(dev_ready),
      .rsp_pending(rsp_pending), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
      .rsp_last(rsp_last), .rsp_take(rsp_take), .addressed(addressed), .talking(talking));
   mpsl_host #(.DIV(DIV)) u_host (.clk_sys(clk_sys), .txd(txd), .rxd(rxd),
      .rx_byte(h_byte), .rx_stb(h_stb));

   // Compare helpers and closing report
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic pop_chk(input string what, ref logic [7:0] q[$], input logic [7:0] s);
      if (q.size() > 0) begin
         chk(what, q.pop_front(), s);
      end else begin
         n_checks++;
         mismatches++;
         $display("mismatch %s expected none seen %h", what, s);
      end
   endtask
   task automatic test_done();
      int left;
      left = exp_tx.size() + exp_cmd.size() + exp_end.size();
      if (left > 0) begin
         mismatches++;
         $display("mismatch pending notes expected 0 seen %0d", left);
      end
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic sendv(input logic [7:0] b[$]);
      foreach (b[i]) u_host.send_byte(b[i]);
   endtask
   task automatic prefix(input logic [15:0] sfx);
      sendv('{g_hi, g_lo, u_hi, u_lo, sfx[15:8], sfx[7:0]});
   endtask
   // Bounded wait until every expected device byte has been seen
   task automatic drain();
      int n;
      n = 0;
      while (exp_tx.size() > 0 && n < 20000) begin
         @(posedge clk_sys);
         n++;
      end
      if (exp_tx.size() > 0) begin
         mismatches++;
         $display("mismatch device reply expected %0d more seen none", exp_tx.size());
      end
      repeat (4) @(negedge clk_sys);
   endtask

   // Clock and cycle ceiling
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == LIMIT) begin
         mismatches++;
         $display("mismatch timeout expected done seen hang");
         test_done();
      end
   end

   // Output watcher: each result takes the oldest note
   always @(posedge clk_sys) begin
      if (h_stb === 1'b1) pop_chk("txd byte", exp_tx, h_byte);
      if (cmd_valid === 1'b1) pop_chk("cmd_byte", exp_cmd, cmd_byte);
      if ((cmd_done | cmd_abort) !== 1'b0) pop_chk("cmd end", exp_end, {6'h00, cmd_done, cmd_abort});
   end

   // Response source: advance after each consumed byte
   always @(negedge clk_sys) begin
      if (rsp_take === 1'b1 && rsp_q.size() > 0) void'(rsp_q.pop_front());
      rsp_valid <= rsp_q.size() > 0;
      rsp_byte <= (rsp_q.size() > 0) ? rsp_q[0] : 8'h00;
      rsp_last <= rsp_q.size() == 1;
   end

   // Main sequence
   initial begin
      resetn = 1'b0;
      dev_ready = 1'b0;
      rsp_pending = 1'b0;
      cfg = '{bcc_en: 1'b1, baud_sel: 4'h9, group_addr: 7'h00, user_addr: 7'h00};
      void'($urandom(21356));
      cfg.group_addr = 7'($urandom % 100);
      cfg.user_addr = 7'($urandom % 100);
      cb = 8'(8'h21 + $urandom % 90);
      g_hi = 8'h30 + 8'(cfg.group_addr / 10);
      g_lo = 8'h30 + 8'(cfg.group_addr % 10);
      u_hi = 8'h30 + 8'(cfg.user_addr / 10);
      u_lo = 8'h30 + 8'(cfg.user_addr % 10);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      resetn = 1'b1;
      // Selection while not ready draws a refusal
      exp_tx.push_back(C_NAK);
      prefix(SELECT_SUFFIX);
      u_host.send_byte(C_ENQ);
      drain();
      chk("addressed", 8'h00, 8'(addressed));
      // Ready device stays silent for another user address
      dev_ready = 1'b1;
      sendv('{g_hi, g_lo, u_hi, u_lo ^ 8'h01,
              SELECT_SUFFIX[15:8], SELECT_SUFFIX[7:0], C_ENQ});
      repeat (12 * DIV) @(negedge clk_sys);
      chk("addressed", 8'h00, 8'(addressed));
      // Fast selection carrying a checked block
      exp_cmd = '{cb, C_LF};
      exp_end.push_back(8'h02);
      exp_tx.push_back(C_ACK);
      prefix(SELECT_SUFFIX);
      sendv('{C_STX, cb, C_LF, C_ETX, (cb ^ C_LF ^ C_ETX) | BCC_MSB});
      drain();
      chk("addressed", 8'h01, 8'(addressed));
      // Corrupted check byte: command dropped, refusal, still selected
      exp_cmd.push_back(cb);
      exp_end.push_back(8'h01);
      exp_tx.push_back(C_NAK);
      sendv('{C_STX, cb, C_ETX, ((cb ^ C_ETX) | BCC_MSB) ^ 8'h01});
      drain();
      chk("addressed", 8'h01, 8'(addressed));
      u_host.end_conn();
      repeat (4) @(negedge clk_sys);
      chk("addressed", 8'h00, 8'(addressed));
      // Check byte off: block ends at ETX; then a block cut short times out
      cfg.bcc_en = 1'b0;
      exp_cmd.push_back(cb);
      exp_cmd.push_back(C_LF);
      exp_cmd.push_back(cb);
      exp_end.push_back(8'h02);
      exp_end.push_back(8'h01);
      exp_tx.push_back(C_ACK);
      prefix(SELECT_SUFFIX);
      sendv('{C_STX, cb, C_LF, C_ETX});
      drain();
      sendv('{C_STX, cb});
      repeat (TMO + 2 * DIV) @(negedge clk_sys);
      chk("addressed", 8'h00, 8'(addressed));
      cfg.bcc_en = 1'b1;
      // Poll with a waiting response; host stays silent afterwards
      rsp_q = '{8'h4F, 8'h4B};
      rsp_pending = 1'b1;
      exp_tx = '{C_STX, 8'h4F, 8'h4B, C_ETX, (8'h4F ^ 8'h4B ^ C_ETX) | BCC_MSB};
      prefix(POLL_SUFFIX);
      u_host.send_byte(C_ENQ);
      drain();
      rsp_pending = 1'b0;
      t0 = cyc;
      chk("talking", 8'h01, 8'(talking));
      exp_tx.push_back(C_EOT);
      drain();
      chk("ack wait", 8'h01, 8'((cyc - t0 >= TMO - DIV) && (cyc - t0 <= TMO + 12 * DIV)));
      repeat (DIV) @(negedge clk_sys);
      chk("talking", 8'h00, 8'(talking));
      // Poll with nothing waiting
      exp_tx.push_back(C_EOT);
      prefix(POLL_SUFFIX);
      u_host.send_byte(C_ENQ);
      drain();
      test_done();
   end
endmodule

// ==== verilog/mpsl_link.sv ====
// Slave-side select/poll protocol engine for a multipoint serial link
//
// What this block does
// - Baud rate chosen from ten rates 300 to 57600, no handshake lines.
// - Block check append and check switchable, enabled by default.
// - Control bytes EOT 04, NAK 15, CR 0D, LF 0A, ENQ 05, ETX 03.
// - Commands arrive as STX, text, LF, ETX.
// - One master and one slave at a time; no station-to-station traffic.
// - Without a connection the device is neither slave nor talker.
// - Selection is group, user address, select suffix, then ENQ.
// - Own selection: if ready reply ACK and become slave, else reply NAK and stay idle.
// - Fast selection: prefix then STX block directly, no ENQ.
// - Polling is group, user address, poll suffix, then ENQ.
// - Polled with data: send a block; with none: send EOT.
// - Sent blocks are STX, payload, ETX, then check byte if enabled.
// - Check byte is XOR of bytes after STX through ETX, OR 80 hex.
// - After a block answer ACK if accepted and ready, else NAK.
// - Master without further data sends EOT, ending the exchange.
// - After sending ETX wait 5 s for ACK, else send EOT and idle.
// - Receive timer restarts per byte; 5 s silence drops command, idle.
module mpsl_link
   import mpsl_pkg::*;
#(
   parameter int unsigned TMO_CYCLES = TMO_CYC,
   parameter int unsigned CLK_FREQ = CLK_HZ
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Configuration
   input wire mpsl_cfg_t cfg,
   // Serial pins
   input wire logic rxd,
   output logic txd,
   // Command stream towards the instrument
   output logic [7:0] cmd_byte,
   output logic cmd_valid,
   output logic cmd_done,
   output logic cmd_abort,
   input wire logic dev_ready,
   // Response stream from the instrument
   input wire logic rsp_pending,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_byte,
   input wire logic rsp_last,
   output logic rsp_take,
   // Link status
   output logic addressed,
   output logic talking
);

   typedef enum {S_IDLE, S_SEL, S_RX_BLK, S_RX_BCC, S_TX_STX, S_TX_DATA,
                 S_TX_ETX, S_TX_BCC, S_WAIT_ACK} mpsl_state_t;

   mpsl_state_t st_r, st_nxt;
   logic [47:0] pfx_r, pfx_nxt;
   logic [7:0] bcc_r, bcc_nxt;
   logic [TMO_W-1:0] tmo_r, tmo_nxt;
   logic tx_start_r, tx_start_nxt;
   logic [7:0] tx_data_r, tx_data_nxt;
   logic [7:0] cmd_byte_r, cmd_byte_nxt;
   logic cmd_valid_r, cmd_valid_nxt;
   logic cmd_done_r, cmd_done_nxt;
   logic cmd_abort_r, cmd_abort_nxt;
   logic rsp_take_r, rsp_take_nxt;
   logic addr_r, addr_nxt;
   logic talk_r, talk_nxt;
   logic [7:0] rx_data;
   logic rx_valid;
   logic tx_busy;
   logic [47:0] sel_pfx;
   logic [47:0] poll_pfx;
   logic can_send;
   logic tmo_hit;
   logic blk_ok;

   // ----------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------
   mpsl_uart u_uart (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .div(mpsl_baud_div(cfg.baud_sel, CLK_FREQ)),
      .rxd(rxd),
      .txd(txd),
      .rx_data(rx_data),
      .rx_valid(rx_valid),
      .tx_start(tx_start_r),
      .tx_data(tx_data_r),
      .tx_busy(tx_busy)
   );

   // Expected prefixes; an address above 99 never matches two digits
   assign sel_pfx = {mpsl_dec2(cfg.group_addr), mpsl_dec2(cfg.user_addr),
                     SELECT_SUFFIX};
   assign poll_pfx = {mpsl_dec2(cfg.group_addr), mpsl_dec2(cfg.user_addr),
                      POLL_SUFFIX};
   // Guard against overlapping a byte still leaving the shifter
   assign can_send = !tx_start_r && !tx_busy;
   assign tmo_hit = (32'(tmo_r) >= TMO_CYCLES - 1);

   assign cmd_byte = cmd_byte_r;
   assign cmd_valid = cmd_valid_r;
   assign cmd_done = cmd_done_r;
   assign cmd_abort = cmd_abort_r;
   assign rsp_take = rsp_take_r;
   assign addressed = addr_r;
   assign talking = talk_r;

   // ----------------------------------------------------------------
   // Protocol state machine
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      pfx_nxt = pfx_r;
      bcc_nxt = bcc_r;
      tmo_nxt = rx_valid ? '0 : (tmo_hit ? tmo_r : tmo_r + 1'b1);
      tx_start_nxt = 1'b0;
      tx_data_nxt = tx_data_r;
      cmd_byte_nxt = cmd_byte_r;
      cmd_valid_nxt = 1'b0;
      cmd_done_nxt = 1'b0;
      cmd_abort_nxt = 1'b0;
      rsp_take_nxt = 1'b0;
      blk_ok = 1'b0;
      case (st_r)
         S_IDLE, S_SEL: begin
            if (rx_valid) begin
               pfx_nxt = 48'h0000_0000_0000;
               if (rx_data == C_EOT) begin
                  st_nxt = S_IDLE;
               end else if (rx_data == C_ENQ && pfx_r == sel_pfx) begin
                  tx_start_nxt = 1'b1;
                  tx_data_nxt = dev_ready ? C_ACK : C_NAK;
                  st_nxt = dev_ready ? S_SEL : S_IDLE;
               end else if (rx_data == C_ENQ && pfx_r == poll_pfx) begin
                  if (rsp_pending) begin
                     st_nxt = S_TX_STX;
                  end else begin
                     tx_start_nxt = 1'b1;
                     tx_data_nxt = C_EOT;
                     st_nxt = S_IDLE;
                  end
               end else if (rx_data == C_STX && (st_r == S_SEL || pfx_r == sel_pfx)) begin
                  bcc_nxt = 8'h00;
                  st_nxt = S_RX_BLK;
               end else if (rx_data != C_ENQ && rx_data != C_STX) begin
                  pfx_nxt = {pfx_r[39:0], rx_data};
               end
            end
         end
         S_RX_BLK, S_RX_BCC: begin
            if (rx_valid) begin
               if (st_r == S_RX_BCC || (rx_data == C_ETX && !cfg.bcc_en)) begin
                  blk_ok = dev_ready &&
                     (st_r == S_RX_BLK || rx_data == (bcc_r | BCC_MSB));
                  tx_start_nxt = 1'b1;
                  tx_data_nxt = blk_ok ? C_ACK : C_NAK;
                  cmd_done_nxt = blk_ok;
                  cmd_abort_nxt = !blk_ok;
                  st_nxt = S_SEL;
               end else if (rx_data == C_ETX) begin
                  bcc_nxt = bcc_r ^ rx_data;
                  st_nxt = S_RX_BCC;
               end else begin
                  bcc_nxt = bcc_r ^ rx_data;
                  cmd_byte_nxt = rx_data;
                  cmd_valid_nxt = 1'b1;
               end
            end else if (tmo_hit) begin
               cmd_abort_nxt = 1'b1;
               st_nxt = S_IDLE;
            end
         end
         S_TX_STX: begin
            if (can_send) begin
               tx_start_nxt = 1'b1;
               tx_data_nxt = C_STX;
               bcc_nxt = 8'h00;
               st_nxt = S_TX_DATA;
            end
         end
         S_TX_DATA: begin
            if (can_send && rsp_valid) begin
               tx_start_nxt = 1'b1;
               tx_data_nxt = rsp_byte;
               bcc_nxt = bcc_r ^ rsp_byte;
               rsp_take_nxt = 1'b1;
               st_nxt = rsp_last ? S_TX_ETX : S_TX_DATA;
            end
         end
         S_TX_ETX: begin
            if (can_send) begin
               tx_start_nxt = 1'b1;
               tx_data_nxt = C_ETX;
               bcc_nxt = bcc_r ^ C_ETX;
               st_nxt = cfg.bcc_en ? S_TX_BCC : S_WAIT_ACK;
            end
         end
         S_TX_BCC: begin
            if (can_send) begin
               tx_start_nxt = 1'b1;
               tx_data_nxt = bcc_r | BCC_MSB;
               st_nxt = S_WAIT_ACK;
            end
         end
         default: begin
            if (rx_valid && rx_data == C_ACK && rsp_pending) begin
               st_nxt = S_TX_STX;
            end else if (rx_valid || tmo_hit) begin
               tx_start_nxt = 1'b1;
               tx_data_nxt = C_EOT;
               st_nxt = S_IDLE;
            end
         end
      endcase
      if (st_nxt != st_r) begin
         tmo_nxt = '0;
      end
      addr_nxt = (st_nxt == S_SEL || st_nxt == S_RX_BLK || st_nxt == S_RX_BCC);
      talk_nxt = !(st_nxt == S_IDLE || addr_nxt);
   end

   // Registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_r <= S_IDLE;
         pfx_r <= 48'h0000_0000_0000;
         bcc_r <= 8'h00;
         tmo_r <= '0;
         tx_start_r <= 1'b0;
         tx_data_r <= 8'h00;
         cmd_byte_r <= 8'h00;
         cmd_valid_r <= 1'b0;
         cmd_done_r <= 1'b0;
         cmd_abort_r <= 1'b0;
         rsp_take_r <= 1'b0;
         addr_r <= 1'b0;
         talk_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         pfx_r <= pfx_nxt;
         bcc_r <= bcc_nxt;
         tmo_r <= tmo_nxt;
         tx_start_r <= tx_start_nxt;
         tx_data_r <= tx_data_nxt;
         cmd_byte_r <= cmd_byte_nxt;
         cmd_valid_r <= cmd_valid_nxt;
         cmd_done_r <= cmd_done_nxt;
         cmd_abort_r <= cmd_abort_nxt;
         rsp_take_r <= rsp_take_nxt;
         addr_r <= addr_nxt;
         talk_r <= talk_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_select_reply: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_r == S_IDLE && rx_valid && rx_data == C_ENQ && pfx_r == sel_pfx)
      |=> tx_start_r && tx_data_r == ($past(dev_ready) ? C_ACK : C_NAK))
      else $error("selection reply wrong");
   a_poll_empty: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_r == S_IDLE && rx_valid && rx_data == C_ENQ && pfx_r == poll_pfx && !rsp_pending)
      |=> tx_start_r && tx_data_r == C_EOT && st_r == S_IDLE)
      else $error("empty poll not answered by EOT");
   a_poll_block: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_r == S_TX_STX && can_send) |=> tx_start_r && tx_data_r == C_STX)
      else $error("block does not open with STX");
   a_bcc_msb: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_r == S_TX_BCC && can_send) |=> tx_start_r && tx_data_r[7] && $past(cfg.bcc_en, 2))
      else $error("check byte without top bit");
   a_bcc_reject: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_r == S_RX_BCC && rx_valid && rx_data != (bcc_r | BCC_MSB))
      |=> tx_start_r && tx_data_r == C_NAK && cmd_abort_r && !cmd_done_r)
      else $error("bad check byte accepted");
   a_rx_timeout: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_r == S_RX_BLK && !rx_valid && tmo_hit) |=> st_r == S_IDLE && cmd_abort_r)
      else $error("receive timeout not taken");
   a_ack_timeout: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_r == S_WAIT_ACK && !rx_valid && tmo_hit)
      |=> st_r == S_IDLE ##0 tx_start_r && tx_data_r == C_EOT)
      else $error("no EOT after acknowledge timeout");
   a_eot_release: assert property (@(posedge clk_sys) disable iff (!resetn)
      ((st_r == S_IDLE || st_r == S_SEL) && rx_valid && rx_data == C_EOT)
      |=> !addressed ##1 !addressed && !talking)
      else $error("EOT did not drop the connection");
   a_no_overlap: assert property (@(posedge clk_sys) disable iff (!resetn)
      (tx_start_r && talking) |-> !tx_busy)
      else $error("byte sent over a busy transmitter");

endmodule

// ==== verilog/mpsl_uart.sv ====
// Byte-wide asynchronous serial transmitter and receiver, 8 data bits, 1 stop bit
module mpsl_uart
   import mpsl_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Bit period in clocks
   input wire logic [DIV_W-1:0] div,
   // Serial pins
   input wire logic rxd,
   output logic txd,
   // Receive side
   output logic [7:0] rx_data,
   output logic rx_valid,
   // Transmit side
   input wire logic tx_start,
   input wire logic [7:0] tx_data,
   output logic tx_busy
);

   logic rx_act_r, rx_act_nxt;
   logic [DIV_W-1:0] rx_cnt_r, rx_cnt_nxt;
   logic [3:0] rx_bit_r, rx_bit_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt;
   logic rx_vld_r, rx_vld_nxt;
   logic tx_act_r, tx_act_nxt;
   logic [DIV_W-1:0] tx_cnt_r, tx_cnt_nxt;
   logic [3:0] tx_bit_r, tx_bit_nxt;
   logic [9:0] tx_sh_r, tx_sh_nxt;

   assign rx_data = rx_sh_r;
   assign rx_valid = rx_vld_r;
   assign txd = tx_sh_r[0];
   assign tx_busy = tx_act_r;

   // ----------------------------------------------------------------
   // Next-state logic; receiver samples mid-bit, no handshake lines
   // ----------------------------------------------------------------
   always_comb begin
      rx_act_nxt = rx_act_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_bit_nxt = rx_bit_r;
      rx_sh_nxt = rx_sh_r;
      rx_vld_nxt = 1'b0;
      if (!rx_act_r) begin
         if (!rxd) begin
            rx_act_nxt = 1'b1;
            rx_cnt_nxt = div >> 1;
            rx_bit_nxt = 4'h0;
         end
      end else if (rx_cnt_r != '0) begin
         rx_cnt_nxt = rx_cnt_r - 1'b1;
      end else begin
         rx_cnt_nxt = div - 1'b1;
         rx_bit_nxt = rx_bit_r + 1'b1;
         if (rx_bit_r == 4'h0) begin
            rx_act_nxt = !rxd;   // Glitch on start bit drops the frame
         end else if (rx_bit_r <= UART_BITS) begin
            rx_sh_nxt = {rxd, rx_sh_r[7:1]};
         end else begin
            rx_act_nxt = 1'b0;
            rx_vld_nxt = rxd;    // Framing error discards the byte
         end
      end
      tx_act_nxt = tx_act_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_bit_nxt = tx_bit_r;
      tx_sh_nxt = tx_sh_r;
      if (!tx_act_r) begin
         if (tx_start) begin
            tx_act_nxt = 1'b1;
            tx_sh_nxt = {1'b1, tx_data, 1'b0};
            tx_cnt_nxt = div - 1'b1;
            tx_bit_nxt = 4'h0;
         end
      end else if (tx_cnt_r != '0) begin
         tx_cnt_nxt = tx_cnt_r - 1'b1;
      end else begin
         tx_cnt_nxt = div - 1'b1;
         tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
         tx_bit_nxt = tx_bit_r + 1'b1;
         if (tx_bit_r == UART_BITS + 4'h1) begin
            tx_act_nxt = 1'b0;
         end
      end
   end

   // Registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_act_r <= 1'b0;
         rx_cnt_r <= '0;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 8'h00;
         rx_vld_r <= 1'b0;
         tx_act_r <= 1'b0;
         tx_cnt_r <= '0;
         tx_bit_r <= 4'h0;
         tx_sh_r <= 10'h3FF;
      end else begin
         rx_act_r <= rx_act_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_vld_r <= rx_vld_nxt;
         tx_act_r <= tx_act_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_sh_r <= tx_sh_nxt;
      end
   end

endmodule
